// ==== rtl/link_error_selftest_regs.sv ====
// link error counter, self-test control, strap status and indirect access registers
//
// Contract
// - data register write forwards byte to target
// - data register read returns target register
// - output mode 00 off, 10 on
// - source bit selects pin or register setup
// - enable copies clock source to remote 0x14
// - enable bit starts self-test, resets zero
// - address strap done reads one after latch
// - bits 6:4 hold latched address strap code
// - config strap done reads one after latch
// - bits 2:0 hold latched config strap code
// - filter-wait ignore bit masks errors in wait
// - bit 4 enables link error counting
// - counter on pixel clock, three error kinds
// - lock lost when count reaches threshold
// - counting disabled: first error drops lock
// - block select chooses indirect target
// - offset register gives indirect target offset
// - auto-increment bumps offset after each access
// - prefetch strobe on offset write, data read with auto-increment
`timescale 1ns/1ps
`include "link_error_selftest_defs.svh"

module link_error_selftest_regs
(
   // clock and reset
   input  wire logic                               clock,
   input  wire logic                               rst_n,
   // host register access
   input  wire link_error_selftest_pkg::host_req_s hostReq,
   output logic [7:0]                              hostRdata,
   // indirect window
   output link_error_selftest_pkg::ind_req_s       indReq,
   input  wire logic [7:0]                         indRdata,
   // strap pins
   input  wire logic [2:0]                         addrStrapPin,
   input  wire logic [2:0]                         cfgStrapPin,
   // self-test
   input  wire logic                               selftestPin,
   output logic                                    selftestActive,
   output logic                                    selftestOutputsOn,
   output logic                                    remoteWrValid,
   input  wire logic                               remoteWrReady,
   output logic [7:0]                              remoteWrOffset,
   output logic [7:0]                              remoteWrData,
   // forward link
   input  wire logic                               pixelClkPin,
   input  wire link_error_selftest_pkg::link_err_s linkErr,
   input  wire logic                               filterWait,
   input  wire logic                               rxLockPin,
   output logic                                    linkLocked,
   output logic [3:0]                              linkErrCount
);

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   logic [5:0]                       indCtl_q;
   logic [7:0]                       indOffset_q;
   logic [7:0]                       indData_q;
   logic [7:0]                       selftest_q;
   logic [7:0]                       rsvd_q [4];
   logic [5:0]                       linkErrCtl_q;
   logic [7:0]                       hostRdata_q;
   link_error_selftest_pkg::ind_req_s indReq_q;

   logic wrData;
   logic rdData;
   logic autoInc;
   logic prefetch;
   assign wrData   = hostReq.wr && hit(hostReq.addr, `OFS_IND_DATA);
   assign rdData   = hostReq.rd && hit(hostReq.addr, `OFS_IND_DATA);
   assign autoInc  = indCtl_q[1];
   assign prefetch = indCtl_q[0];

   // control register writes
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         indCtl_q     <= `RST_IND_CTL;
         indData_q    <= `RST_IND_DATA;
         selftest_q   <= `RST_SELFTEST;
         linkErrCtl_q <= `RST_LINK_ERR;
      end
      else if (hostReq.wr)
      begin
         if (hit(hostReq.addr, `OFS_IND_CTL))
            indCtl_q <= hostReq.wdata[5:0];
         if (wrData)
            indData_q <= hostReq.wdata;
         if (hit(hostReq.addr, `OFS_SELFTEST))
            selftest_q <= hostReq.wdata;
         if (hit(hostReq.addr, `OFS_LINK_ERR))
            linkErrCtl_q <= hostReq.wdata[5:0];
      end
   end

   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : gRsvd
         localparam logic [7:0] OFS = `OFS_RSVD_B4 + 8'(g);
         always_ff @(posedge clock)
         begin
            if (!rst_n)
               rsvd_q[g] <= (g == 0) ? `RST_RSVD_B4 : (g == 1) ? `RST_RSVD_B5 :
                            (g == 2) ? `RST_RSVD_B6 : `RST_RSVD_B7;
            else if (hostReq.wr && hit(hostReq.addr, OFS))
               rsvd_q[g] <= hostReq.wdata;
         end
      end
   endgenerate

   // offset register and auto-increment
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         indOffset_q <= `RST_IND_OFFSET;
      else if (hostReq.wr && hit(hostReq.addr, `OFS_IND_OFFSET))
         indOffset_q <= hostReq.wdata;
      else if ((wrData || rdData) && autoInc)
         indOffset_q <= indOffset_q + 8'h01;
   end

   // indirect strobes
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         indReq_q <= '0;
      end
      else
      begin
         indReq_q.wrStrobe    <= wrData;
         indReq_q.wdata       <= wrData ? hostReq.wdata : indReq_q.wdata;
         indReq_q.rdStrobe    <= prefetch &&
                                 ((hostReq.wr && hit(hostReq.addr, `OFS_IND_OFFSET)) ||
                                  (rdData && autoInc));
         indReq_q.blockSelect <= indCtl_q[5:2];
         indReq_q.offset      <= indOffset_q;
      end
   end
   always_comb
   begin
      indReq             = indReq_q;
      indReq.blockSelect = (wrData || rdData) ? indCtl_q[5:2] : indReq_q.blockSelect;
      indReq.offset      = indReq_q.wrStrobe ? indReq_q.offset : indOffset_q;
      indReq.blockSelect = indReq_q.wrStrobe ? indReq_q.blockSelect : indCtl_q[5:2];
   end

   // strap capture after reset release
   logic [2:0] addrS1_q, addrS2_q, addrS3_q;
   logic [2:0] cfgS1_q, cfgS2_q, cfgS3_q;
   logic [2:0] addrCode_q, cfgCode_q;
   logic       addrDone_q, cfgDone_q;
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         addrS1_q <= 3'h0;
         addrS2_q <= 3'h0;
         addrS3_q <= 3'h0;
         cfgS1_q  <= 3'h0;
         cfgS2_q  <= 3'h0;
         cfgS3_q  <= 3'h0;
      end
      else
      begin
         addrS1_q <= addrStrapPin;
         addrS2_q <= addrS1_q;
         addrS3_q <= addrS2_q;
         cfgS1_q  <= cfgStrapPin;
         cfgS2_q  <= cfgS1_q;
         cfgS3_q  <= cfgS2_q;
      end
   end
   logic [1:0] strapAge_q;
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         strapAge_q <= 2'h0;
         addrDone_q <= 1'b0;
         cfgDone_q  <= 1'b0;
         addrCode_q <= 3'h0;
         cfgCode_q  <= 3'h0;
      end
      else
      begin
         if (strapAge_q != 2'h3)
            strapAge_q <= strapAge_q + 2'h1;
         if (strapAge_q == 2'h3 && !addrDone_q && addrS2_q == addrS3_q)
         begin
            addrCode_q <= addrS3_q;
            addrDone_q <= 1'b1;
         end
         if (strapAge_q == 2'h3 && !cfgDone_q && cfgS2_q == cfgS3_q)
         begin
            cfgCode_q <= cfgS3_q;
            cfgDone_q <= 1'b1;
         end
      end
   end

   // self-test enable and pin sync
   logic stPin1_q, stPin2_q, stPin3_q, stPinLvl_q;
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         stPin1_q   <= 1'b0;
         stPin2_q   <= 1'b0;
         stPin3_q   <= 1'b0;
         stPinLvl_q <= 1'b0;
      end
      else
      begin
         stPin1_q <= selftestPin;
         stPin2_q <= stPin1_q;
         stPin3_q <= stPin2_q;
         if (stPin2_q == stPin3_q)
            stPinLvl_q <= stPin3_q;
      end
   end
   logic stActive_q;
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         stActive_q <= 1'b0;
      else
         stActive_q <= selftest_q[`ST_PIN_BIT] ? stPinLvl_q : selftest_q[`ST_EN_BIT];
   end
   assign selftestActive    = stActive_q;
   assign selftestOutputsOn = stActive_q &&
                              (selftest_q[`ST_MODE_HI:`ST_MODE_LO] == `ST_MODE_OUT_ON);

   // remote clock source write on self-test start
   link_error_selftest_pkg::remote_e remote_q;
   logic [7:0]                       remoteData_q;
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         remote_q     <= link_error_selftest_pkg::REMOTE_IDLE;
         remoteData_q <= `ZERO_BYTE;
      end
      else
      begin
         unique case (remote_q)
            link_error_selftest_pkg::REMOTE_IDLE:
               if (stActive_q)
               begin
                  remote_q     <= link_error_selftest_pkg::REMOTE_SEND;
                  remoteData_q <= {6'h00, selftest_q[`ST_CLK_HI:`ST_CLK_LO]};
               end
            link_error_selftest_pkg::REMOTE_SEND:
               if (remoteWrReady)
                  remote_q <= link_error_selftest_pkg::REMOTE_DONE;
            link_error_selftest_pkg::REMOTE_DONE:
               if (!stActive_q)
                  remote_q <= link_error_selftest_pkg::REMOTE_IDLE;
         endcase
      end
   end
   assign remoteWrValid  = (remote_q == link_error_selftest_pkg::REMOTE_SEND);
   assign remoteWrOffset = `REMOTE_CLK_OFS;
   assign remoteWrData   = remoteData_q;

   // link-side inputs, three-flop synchronisers
   localparam int NLNK = 6;
   logic [NLNK-1:0] lnkIn;
   logic [NLNK-1:0] lnk1_q, lnk2_q, lnk3_q, lnkLvl_q;
   assign lnkIn = {pixelClkPin, rxLockPin, filterWait,
                   linkErr.parityErr, linkErr.clockErr, linkErr.controlErr};
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         lnk1_q   <= '0;
         lnk2_q   <= '0;
         lnk3_q   <= '0;
         lnkLvl_q <= '0;
      end
      else
      begin
         lnk1_q <= lnkIn;
         lnk2_q <= lnk1_q;
         lnk3_q <= lnk2_q;
         for (int i = 0; i < NLNK; i++)
            if (lnk2_q[i] == lnk3_q[i])
               lnkLvl_q[i] <= lnk3_q[i];
      end
   end
   logic pixClk_q, rxLockPrev_q;
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         pixClk_q     <= 1'b0;
         rxLockPrev_q <= 1'b0;
      end
      else
      begin
         pixClk_q     <= lnkLvl_q[5];
         rxLockPrev_q <= lnkLvl_q[4];
      end
   end

   logic pixEdge;
   logic anyErr;
   logic newLock;
   assign pixEdge = lnkLvl_q[5] && !pixClk_q;
   assign anyErr  = pixEdge && (|lnkLvl_q[2:0]) &&
                    !(linkErrCtl_q[`LE_WAIT_BIT] && lnkLvl_q[3]);
   assign newLock = lnkLvl_q[4] && !rxLockPrev_q;

   // error counter and lock decision
   logic [3:0] errCnt_q;
   logic       lockLost_q;
   logic [3:0] thresh;
   assign thresh = linkErrCtl_q[`LE_THR_HI:`LE_THR_LO];
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         errCnt_q   <= 4'h0;
         lockLost_q <= 1'b0;
      end
      else if (newLock)
      begin
         errCnt_q   <= 4'h0;
         lockLost_q <= 1'b0;
      end
      else if (anyErr && !lockLost_q)
      begin
         if (linkErrCtl_q[`LE_CNT_EN_BIT])
         begin
            if (errCnt_q != `ERR_MAX)
               errCnt_q <= errCnt_q + `ERR_ONE;
            if (errCnt_q + `ERR_ONE >= thresh)
               lockLost_q <= 1'b1;
         end
         else
         begin
            lockLost_q <= 1'b1;
         end
      end
   end
   assign linkLocked   = lnkLvl_q[4] && !lockLost_q;
   assign linkErrCount = errCnt_q;

   // register read mux
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         hostRdata_q <= `ZERO_BYTE;
      else if (hostReq.rd)
      begin
         unique case (1'b1)
            hit(hostReq.addr, `OFS_IND_CTL):    hostRdata_q <= {2'h0, indCtl_q};
            hit(hostReq.addr, `OFS_IND_OFFSET): hostRdata_q <= indOffset_q;
            rdData:                             hostRdata_q <= indRdata;
            hit(hostReq.addr, `OFS_SELFTEST):   hostRdata_q <= selftest_q;
            hit(hostReq.addr, `OFS_RSVD_B4):    hostRdata_q <= rsvd_q[0];
            hit(hostReq.addr, `OFS_RSVD_B5):    hostRdata_q <= rsvd_q[1];
            hit(hostReq.addr, `OFS_RSVD_B6):    hostRdata_q <= rsvd_q[2];
            hit(hostReq.addr, `OFS_RSVD_B7):    hostRdata_q <= rsvd_q[3];
            hit(hostReq.addr, `OFS_STRAP_STS):
               hostRdata_q <= {addrDone_q, addrCode_q, cfgDone_q, cfgCode_q};
            hit(hostReq.addr, `OFS_LINK_ERR):   hostRdata_q <= {2'h0, linkErrCtl_q};
            default:                            hostRdata_q <= `ZERO_BYTE;
         endcase
      end
   end
   assign hostRdata = hostRdata_q;

endmodule

// ==== include/link_error_selftest_defs.svh ====
// offsets, field positions, reset values and codes for the link error / self-test registers
`ifndef LINK_ERROR_SELFTEST_DEFS_SVH
`define LINK_ERROR_SELFTEST_DEFS_SVH

`define OFS_IND_CTL       8'hb0
`define OFS_IND_OFFSET    8'hb1
`define OFS_IND_DATA      8'hb2
`define OFS_SELFTEST      8'hb3
`define OFS_RSVD_B4       8'hb4
`define OFS_RSVD_B5       8'hb5
`define OFS_RSVD_B6       8'hb6
`define OFS_RSVD_B7       8'hb7
`define OFS_STRAP_STS     8'hb8
`define OFS_LINK_ERR      8'hb9

`define RST_IND_CTL       6'h00
`define RST_IND_OFFSET    8'h00
`define RST_IND_DATA      8'h00
`define RST_SELFTEST      8'h08
`define RST_RSVD_B4       8'h25
`define RST_RSVD_B5       8'h00
`define RST_RSVD_B6       8'h18
`define RST_RSVD_B7       8'h00
`define RST_LINK_ERR      6'h33

`define ST_EN_BIT         0
`define ST_CLK_HI         2
`define ST_CLK_LO         1
`define ST_PIN_BIT        3
`define ST_MODE_HI        7
`define ST_MODE_LO        6
`define ST_MODE_OUT_ON    2'b10

`define LE_WAIT_BIT       5
`define LE_CNT_EN_BIT     4
`define LE_THR_HI         3
`define LE_THR_LO         0

`define REMOTE_CLK_OFS    8'h14
`define ZERO_BYTE         8'h00
`define ERR_ONE           4'h1
`define ERR_MAX           4'hf
`endif

// ==== include/link_error_selftest_pkg.sv ====
// types shared by the link error / self-test register block
package link_error_selftest_pkg;

   // host-side register access port behind the i2c slave
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } host_req_s;

   // indirect register window towards internal blocks
   typedef struct packed {
      logic       wrStrobe;
      logic       rdStrobe;
      logic [3:0] blockSelect;
      logic [7:0] offset;
      logic [7:0] wdata;
   } ind_req_s;

   // forward-link error flags from the receiver
   typedef struct packed {
      logic parityErr;
      logic clockErr;
      logic controlErr;
   } link_err_s;

   typedef enum logic [1:0] {
      REMOTE_IDLE,
      REMOTE_SEND,
      REMOTE_DONE
   } remote_e;

endpackage

// ==== verification/link_error_selftest_regs_chk.sv ====
// port assertions for the link error / self-test register block
`timescale 1ns/1ps
`include "link_error_selftest_defs.svh"
module link_error_selftest_regs_chk
(
   // clock and reset
   input wire logic                               clock,
   input wire logic                               rst_n,
   // host and indirect side
   input wire link_error_selftest_pkg::host_req_s hostReq,
   input wire logic [7:0]                         hostRdata,
   input wire link_error_selftest_pkg::ind_req_s  indReq,
   input wire logic [7:0]                         indRdata,
   // self-test and link
   input wire logic                               selftestActive,
   input wire logic                               selftestOutputsOn,
   input wire logic                               remoteWrValid,
   input wire logic                               remoteWrReady,
   input wire logic [7:0]                         remoteWrOffset,
   input wire logic                               linkLocked,
   input wire logic [3:0]                         linkErrCount
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);

   property p_wr_fwd;
      hostReq.wr && hostReq.addr == `OFS_IND_DATA
         |=> indReq.wrStrobe && indReq.wdata == $past(hostReq.wdata);
   endproperty
   a_wr_fwd: assert property (p_wr_fwd) else $error("data write not forwarded");
   property p_wr_src;
      indReq.wrStrobe |-> $past(hostReq.wr) && $past(hostReq.addr) == `OFS_IND_DATA;
   endproperty
   a_wr_src: assert property (p_wr_src) else $error("spurious indirect write");
   property p_rd_ret;
      hostReq.rd && hostReq.addr == `OFS_IND_DATA |=> hostRdata == $past(indRdata);
   endproperty
   a_rd_ret: assert property (p_rd_ret) else $error("data read wrong");
   property p_rd_hold;
      !$past(hostReq.rd) |-> $stable(hostRdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data changed");
   property p_outs_on;
      selftestOutputsOn |-> selftestActive;
   endproperty
   a_outs_on: assert property (p_outs_on) else $error("outputs on while idle");
   property p_st_en;
      hostReq.wr && hostReq.addr == `OFS_SELFTEST && !hostReq.wdata[3]
         |-> ##2 selftestActive == $past(hostReq.wdata[0], 2);
   endproperty
   a_st_en: assert property (p_st_en) else $error("enable bit ignored");
   property p_remote;
      $rose(selftestActive) |=> remoteWrValid && remoteWrOffset == `REMOTE_CLK_OFS;
   endproperty
   a_remote: assert property (p_remote) else $error("no remote copy");
   property p_rem_hold;
      remoteWrValid && !remoteWrReady |=> remoteWrValid;
   endproperty
   a_rem_hold: assert property (p_rem_hold) else $error("remote write dropped");
   property p_rem_once;
      remoteWrValid && remoteWrReady |=> !remoteWrValid [*2];
   endproperty
   a_rem_once: assert property (p_rem_once) else $error("remote write resent");
   property p_cnt_step;
      linkErrCount != $past(linkErrCount)
         |-> linkErrCount == $past(linkErrCount) + 4'h1 || linkErrCount == 4'h0;
   endproperty
   a_cnt_step: assert property (p_cnt_step) else $error("counter jumped");
   property p_rd_src;
      indReq.rdStrobe |-> $past(hostReq.wr) && $past(hostReq.addr) == `OFS_IND_OFFSET
         || $past(hostReq.rd) && $past(hostReq.addr) == `OFS_IND_DATA;
   endproperty
   a_rd_src: assert property (p_rd_src) else $error("spurious prefetch");

   c_wr: cover property (indReq.wrStrobe);
   c_rem: cover property (remoteWrValid && remoteWrReady);
   c_loss: cover property ($fell(linkLocked));
endmodule

bind link_error_selftest_regs link_error_selftest_regs_chk chk_u (.clock, .rst_n,
   .hostReq, .hostRdata, .indReq, .indRdata, .selftestActive, .selftestOutputsOn,
   .remoteWrValid, .remoteWrReady, .remoteWrOffset, .linkLocked, .linkErrCount);

// ==== verification/remote_serializer_model.sv ====
// far-side serializer model: pixel clock, error flags, lock and remote register
`timescale 1ns/1ps
module remote_serializer_model
(
   // clock and reset
   input  wire logic                               clock,
   input  wire logic                               rst_n,
   // bench control
   input  wire logic                               lockOn,
   input  wire logic                               errStart,
   input  wire link_error_selftest_pkg::link_err_s errKind,
   input  wire logic [3:0]                         errNum,
   input  wire logic [3:0]                         readyDelay,
   output logic [3:0]                              errLeft_q,
   output logic [1:0]                              clkSrc_q,
   output logic [7:0]                              nWrites_q,
   // link side
   output logic                                    pixelClkPin,
   output link_error_selftest_pkg::link_err_s      linkErr,
   output logic                                    rxLockPin,
   input  wire logic                               remoteWrValid,
   output logic                                    remoteWrReady,
   input  wire logic [7:0]                         remoteWrOffset,
   input  wire logic [7:0]                         remoteWrData
);
   logic [3:0] phase_q;
   logic [3:0] wait_q;
   // pixel clock stands still while unlocked
   assign pixelClkPin = lockOn & phase_q[3];
   assign rxLockPin   = lockOn;
   // errors change on falling pixel edge
   always_ff @(posedge clock)
   begin
      phase_q <= rst_n ? phase_q + 4'h1 : 4'h0;
      if (!rst_n)
         linkErr <= '0;
      else if (phase_q == 4'hf)
         linkErr <= (errLeft_q != 4'h0) ? errKind : '0;
      if (!rst_n)
         errLeft_q <= 4'h0;
      else if (errStart)
         errLeft_q <= errNum;
      else if (phase_q == 4'hf && errLeft_q != 4'h0)
         errLeft_q <= errLeft_q - 4'h1;
   end
   // accept remote write after a programmable stall
   always_ff @(posedge clock)
   begin
      wait_q        <= (remoteWrValid && !remoteWrReady) ? wait_q + 4'h1 : 4'h0;
      remoteWrReady <= rst_n && remoteWrValid && !remoteWrReady && wait_q == readyDelay;
      if (!rst_n)
         nWrites_q <= 8'h00;
      else if (remoteWrValid && remoteWrReady && remoteWrOffset == 8'h14)
      begin
         clkSrc_q  <= remoteWrData[1:0];
         nWrites_q <= nWrites_q + 8'h01;
      end
   end
endmodule

// ==== verification/link_error_selftest_regs_bench.sv ====
// self-checking bench for the link error / self-test register block
`timescale 1ns/1ps
`include "link_error_selftest_defs.svh"
module link_error_selftest_regs_bench;
   logic                               clock = 1'b0;
   logic                               rst_n = 1'b0;
   link_error_selftest_pkg::host_req_s hostReq = '0;
   link_error_selftest_pkg::ind_req_s  indReq;
   link_error_selftest_pkg::link_err_s linkErr;
   link_error_selftest_pkg::link_err_s errKind = '0;
   logic [7:0]                         hostRdata, remoteWrOffset, remoteWrData, nWrites;
   logic [7:0]                         indRdata = 8'h00;
   logic                               selftestPin = 1'b0, filterWait = 1'b0;
   logic                               lockOn = 1'b0, errStart = 1'b0;
   logic                               selftestActive, selftestOutputsOn, remoteWrValid;
   logic                               remoteWrReady, pixelClkPin, rxLockPin, linkLocked;
   logic [3:0]                         linkErrCount, errLeft;
   logic [3:0]                         errNum = 4'h0, readyDelay = 4'h0;
   logic [1:0]                         clkSrc;
   int                                 nMismatch = 0, samplesChecked = 0;

   always #25 clock = ~clock;

   link_error_selftest_regs dut_u (.clock, .rst_n, .hostReq, .hostRdata, .indReq, .indRdata,
      .addrStrapPin(3'h5), .cfgStrapPin(3'h2), .selftestPin, .selftestActive,
      .selftestOutputsOn, .remoteWrValid, .remoteWrReady, .remoteWrOffset, .remoteWrData,
      .pixelClkPin, .linkErr, .filterWait, .rxLockPin, .linkLocked, .linkErrCount);
   remote_serializer_model model_u (.clock, .rst_n, .lockOn, .errStart, .errKind, .errNum,
      .readyDelay, .errLeft_q(errLeft), .clkSrc_q(clkSrc), .nWrites_q(nWrites), .pixelClkPin,
      .linkErr, .rxLockPin, .remoteWrValid, .remoteWrReady, .remoteWrOffset, .remoteWrData);

   task chk(input logic [7:0] got, input logic [7:0] exp);
      samplesChecked++;
      if (got !== exp)
      begin
         nMismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task final_report;
      $display("comparisons %0d mismatches %0d", samplesChecked, nMismatch);
      if (nMismatch == 0 && samplesChecked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task hostAcc(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      hostReq <= '{wr, !wr, a, d};
      @(posedge clock);
      hostReq <= '0;
      #1;
   endtask
   function logic [7:0] probe(input int k);
      return k == 0 ? {7'h00, linkLocked} : k == 1 ? nWrites
         : k == 2 ? {4'h0, errLeft} : {7'h00, selftestActive};
   endfunction
   task waitFor(input int k, input logic [7:0] v);
      for (int i = 0; i < 400 && probe(k) !== v; i++)
      begin
         @(posedge clock);
         #1;
      end
      if (probe(k) !== v)
      begin
         nMismatch++;
         $display("mismatch at %0t: wait ran out", $time);
         final_report;
      end
   endtask
   task inject(input logic [2:0] kind, input logic [3:0] n);
      @(posedge clock);
      errKind  <= kind;
      errNum   <= n;
      errStart <= 1'b1;
      @(posedge clock);
      errStart <= 1'b0;
      waitFor(2, 8'h00);
      repeat (40) @(posedge clock);
      #1;
   endtask
   task relock;
      @(posedge clock);
      lockOn <= 1'b0;
      repeat (8) @(posedge clock);
      lockOn <= 1'b1;
      waitFor(0, 8'h01);
   endtask

   task t_reset;
      logic [7:0] exp [10] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h25, 8'h00, 8'h18, 8'h00,
         8'hda, 8'h33};
      for (int i = 0; i < 10; i++)
      begin
         hostAcc(1'b0, 8'hb0 + 8'(i), 8'h00);
         chk(hostRdata, exp[i]);
      end
      hostAcc(1'b0, 8'ha0, 8'h00);
      chk(hostRdata, 8'h00);
      hostAcc(1'b1, `OFS_STRAP_STS, 8'h00);
      hostAcc(1'b0, `OFS_STRAP_STS, 8'h00);
      chk(hostRdata, 8'hda);
   endtask
   task t_indirect;
      hostAcc(1'b1, `OFS_IND_CTL, 8'h17);
      hostAcc(1'b1, `OFS_IND_OFFSET, 8'h40);
      chk(indReq.rdStrobe, 1'b1);
      chk(indReq.blockSelect, 4'h5);
      chk(indReq.offset, 8'h40);
      hostAcc(1'b1, `OFS_IND_DATA, 8'ha5);
      chk(indReq.wrStrobe, 1'b1);
      chk(indReq.wdata, 8'ha5);
      chk(indReq.offset, 8'h40);
      hostAcc(1'b0, `OFS_IND_OFFSET, 8'h00);
      chk(hostRdata, 8'h41);
      indRdata <= 8'h5a;
      hostAcc(1'b0, `OFS_IND_DATA, 8'h00);
      chk(hostRdata, 8'h5a);
      chk(indReq.rdStrobe, 1'b1);
      chk(indReq.offset, 8'h42);
      hostAcc(1'b1, `OFS_IND_CTL, 8'h00);
      hostAcc(1'b1, `OFS_IND_OFFSET, 8'h07);
      chk(indReq.rdStrobe, 1'b0);
   endtask
   task t_selftest;
      for (int s = 0; s < 3; s++)
      begin
         readyDelay <= 4'(s * 5);
         hostAcc(1'b1, `OFS_SELFTEST, {2'b10, 3'b000, s[1:0], 1'b1});
         // active follows the register one clock later
         @(posedge clock);
         #1;
         chk(selftestActive, 1'b1);
         chk(selftestOutputsOn, 1'b1);
         waitFor(1, 8'(s + 1));
         chk(clkSrc, s[1:0]);
         hostAcc(1'b1, `OFS_SELFTEST, 8'h00);
         chk(nWrites, 8'(s + 1));
      end
      hostAcc(1'b1, `OFS_SELFTEST, 8'h01);
      @(posedge clock);
      #1;
      chk(selftestActive, 1'b1);
      chk(selftestOutputsOn, 1'b0);
      waitFor(1, 8'h04);
      hostAcc(1'b1, `OFS_SELFTEST, 8'h00);
      selftestPin <= 1'b1;
      repeat (10) @(posedge clock);
      #1;
      chk(selftestActive, 1'b0);
      hostAcc(1'b1, `OFS_SELFTEST, 8'h08);
      waitFor(3, 8'h01);
      waitFor(1, 8'h05);
      @(posedge clock);
      selftestPin <= 1'b0;
      waitFor(3, 8'h00);
   endtask
   task t_link;
      relock;
      inject(3'b100, 4'h2);
      chk(linkErrCount, 4'h2);
      chk(linkLocked, 1'b1);
      inject(3'b010, 4'h1);
      chk(linkLocked, 1'b0);
      relock;
      chk(linkErrCount, 4'h0);
      hostAcc(1'b1, `OFS_LINK_ERR, 8'h23);
      inject(3'b001, 4'h1);
      chk(linkLocked, 1'b0);
      relock;
      hostAcc(1'b1, `OFS_LINK_ERR, 8'h33);
      filterWait <= 1'b1;
      inject(3'b100, 4'h4);
      chk(linkLocked, 1'b1);
      hostAcc(1'b1, `OFS_LINK_ERR, 8'h13);
      inject(3'b100, 4'h3);
      chk(linkLocked, 1'b0);
      filterWait <= 1'b0;
   endtask

   initial
   begin
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      repeat (12) @(posedge clock);
      t_reset;
      t_indirect;
      t_selftest;
      t_link;
      final_report;
   end
endmodule
